//--- src/psr_defines.svh
// Behaviour
// - register 1h holds secondary link page low byte
// - link_page_select1_high holds secondary page high byte
// - registers 3h/4h form primary link page selector
// - primary selector decodes to four link pages
// - channel_pairing_control bit0 chooses paired or individual writes
// - analog_page_select selects master or converter analog page
// - two power-down masks at 20h/21h and 23h/24h
// - powerdown_control bit5 chooses mask one or two
// - mask applies only when 55h enable set
// - enable one sleeps masked blocks, zero normal
// - core mask nibbles sleep channel A, B
// - buffer fields: 00 active, 11 asleep
// - global sleep needs pin override set in the same write
// - override set ignores external sleep pin
// - input_coupling_control bit0 drives common-mode lift off
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// ==========================================
// register offsets
`define PSR_ADDR_W          12
`define PSR_OFS_SEC_LOW     12'h001
`define PSR_OFS_SEC_HIGH    12'h002
`define PSR_OFS_PRI_LOW     12'h003
`define PSR_OFS_PRI_HIGH    12'h004
`define PSR_OFS_PAIRING     12'h005
`define PSR_OFS_ANALOG_PAGE 12'h011
`define PSR_OFS_CORE_MASK1  12'h020
`define PSR_OFS_BUF_MASK1   12'h021
`define PSR_OFS_CORE_MASK2  12'h023
`define PSR_OFS_BUF_MASK2   12'h024
`define PSR_OFS_PD_CTRL     12'h026
`define PSR_OFS_COUPLING    12'h04F
`define PSR_OFS_MASK_EN     12'h055

// ==========================================
// reset values and field positions
`define PSR_RESET_BYTE      8'h00
`define PSR_BIT_INDIVIDUAL  0
`define PSR_BIT_GLOBAL      7
`define PSR_BIT_OVERRIDE    6
`define PSR_BIT_MASK_SEL    5
`define PSR_BIT_LIFT_OFF    0
`define PSR_BIT_MASK_EN     4
`define PSR_PD_CTRL_MASK    8'hE0
`define PSR_BUF_MASK_MASK   8'hF0
`define PSR_LOW_BIT_MASK    8'h01
`define PSR_MASK_EN_MASK    8'h10

// ==========================================
// page codes
`define PSR_PAGE_MASTER     8'h80
`define PSR_PAGE_CONVERTER  8'h0F
`define PSR_PAGE_MAIN_DIG   16'h6800
`define PSR_PAGE_LINK_DIG   16'h6900
`define PSR_PAGE_LINK_ANA   16'h6A00
`define PSR_PAGE_OFFSET     16'h6100
`define PSR_PAGE_OFS_LOAD   16'h0500
`define PSR_PAGE_OFS_READ   16'h0000

// ==========================================
// serial frame layout
`define PSR_BIT_CNT_W       5
`define PSR_HDR_BITS        5'h10
`define PSR_FRAME_BITS      5'h18
`define PSR_HDR_READ        15
`define PSR_HDR_BANK        14
`define PSR_HDR_CHAN        13

`endif

//--- src/psr_pkg.sv
package psr_pkg;
  typedef enum logic [1:0] {
    PSR_ST_IDLE  = 2'b01,
    PSR_ST_SHIFT = 2'b10
  } psr_state_t;
endpackage

//--- src/psr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "psr_defines.svh"

module psr_regs
  import psr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        sen_n,
  input  wire logic        sclk,
  input  wire logic        sdin,
  input  wire logic        sleep_pin,
  output logic             sdout,
  output logic [15:0]      link_bank_secondary_page,
  output logic [15:0]      link_bank_primary_page,
  output logic             page_main_digital,
  output logic             page_link_digital,
  output logic             page_link_analog,
  output logic             page_offset_read,
  output logic             page_offset_load,
  output logic             page_master,
  output logic             page_converter,
  output logic             chan_a_write,
  output logic             chan_b_write,
  output logic             wr_bank,
  output logic [11:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic             core_a_sleep,
  output logic             core_b_sleep,
  output logic [1:0]       buffer_a_sleep,
  output logic [1:0]       buffer_b_sleep,
  output logic             whole_chip_sleep,
  output logic             common_mode_lift_off
);

  // ==========================================
  // address decode
  function automatic logic is_general(input logic [11:0] a);
    is_general = (a == `PSR_OFS_SEC_LOW) || (a == `PSR_OFS_SEC_HIGH) ||
                 (a == `PSR_OFS_PRI_LOW) || (a == `PSR_OFS_PRI_HIGH) ||
                 (a == `PSR_OFS_PAIRING) || (a == `PSR_OFS_ANALOG_PAGE);
  endfunction

  function automatic logic is_master(input logic [11:0] a);
    is_master = (a == `PSR_OFS_CORE_MASK1) || (a == `PSR_OFS_BUF_MASK1) ||
                (a == `PSR_OFS_CORE_MASK2) || (a == `PSR_OFS_BUF_MASK2) ||
                (a == `PSR_OFS_PD_CTRL)    || (a == `PSR_OFS_COUPLING) ||
                (a == `PSR_OFS_MASK_EN);
  endfunction

  // ==========================================
  // pin synchronisers
  logic [2:0] sclk_sync_reg;
  logic [1:0] sen_sync_reg;
  logic [1:0] sdin_sync_reg;
  logic [1:0] pin_sync_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sclk_sync_reg <= 3'h0;
      sen_sync_reg  <= 2'h3;
      sdin_sync_reg <= 2'h0;
      pin_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      sen_sync_reg  <= {sen_sync_reg[0], sen_n};
      sdin_sync_reg <= {sdin_sync_reg[0], sdin};
      pin_sync_reg  <= {pin_sync_reg[0], sleep_pin};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sen_act;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign sen_act   = ~sen_sync_reg[1];

  // ==========================================
  // serial frame engine
  psr_state_t                 state_reg;
  logic [`PSR_BIT_CNT_W-1:0]  cnt_reg;
  logic [23:0]                shift_reg;
  logic [7:0]                 rd_shift_reg;
  logic [23:0]                shift_next;
  logic                       hdr_done;
  logic                       frame_done;

  assign shift_next = {shift_reg[22:0], sdin_sync_reg[1]};
  assign hdr_done   = (state_reg == PSR_ST_SHIFT) && sclk_rise &&
                      (cnt_reg == `PSR_HDR_BITS - 5'h01);
  assign frame_done = (state_reg == PSR_ST_SHIFT) && sclk_rise &&
                      (cnt_reg == `PSR_FRAME_BITS - 5'h01) &&
                      !shift_reg[`PSR_HDR_READ + 7];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= PSR_ST_IDLE;
      cnt_reg   <= '0;
      shift_reg <= '0;
    end else begin
      case (state_reg)
        PSR_ST_IDLE: begin
          cnt_reg <= '0;
          if (sen_act) begin
            state_reg <= PSR_ST_SHIFT;
          end
        end
        PSR_ST_SHIFT: begin
          if (!sen_act) begin
            state_reg <= PSR_ST_IDLE;
          end else if (sclk_rise && cnt_reg != `PSR_FRAME_BITS) begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_reg + 5'h01;
          end
        end
        default: state_reg <= PSR_ST_IDLE;
      endcase
    end
  end

  logic        f_bank;
  logic        f_chan;
  logic [11:0] f_addr;
  logic [7:0]  f_data;
  logic        f_local;
  assign f_bank  = shift_reg[`PSR_HDR_BANK + 7];
  assign f_chan  = shift_reg[`PSR_HDR_CHAN + 7];
  assign f_addr  = shift_reg[18:7];
  assign f_data  = shift_next[7:0];

  // ==========================================
  // registers
  logic [7:0] sec_low_reg, sec_high_reg, pri_low_reg, pri_high_reg;
  logic [7:0] pairing_reg, analog_page_reg;
  logic [7:0] core_mask1_reg, buf_mask1_reg, core_mask2_reg, buf_mask2_reg;
  logic [7:0] pd_ctrl_reg, coupling_reg, mask_en_reg;
  logic       master_vis;

  assign master_vis = (analog_page_reg == `PSR_PAGE_MASTER) && !f_bank;
  assign f_local    = !f_bank && (is_general(f_addr) || (master_vis && is_master(f_addr)));

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sec_low_reg     <= `PSR_RESET_BYTE;
      sec_high_reg    <= `PSR_RESET_BYTE;
      pri_low_reg     <= `PSR_RESET_BYTE;
      pri_high_reg    <= `PSR_RESET_BYTE;
      pairing_reg     <= `PSR_RESET_BYTE;
      analog_page_reg <= `PSR_RESET_BYTE;
    end else if (frame_done && !f_bank) begin
      case (f_addr)
        `PSR_OFS_SEC_LOW:     sec_low_reg     <= f_data;
        `PSR_OFS_SEC_HIGH:    sec_high_reg    <= f_data;
        `PSR_OFS_PRI_LOW:     pri_low_reg     <= f_data;
        `PSR_OFS_PRI_HIGH:    pri_high_reg    <= f_data;
        `PSR_OFS_PAIRING:     pairing_reg     <= f_data & `PSR_LOW_BIT_MASK;
        `PSR_OFS_ANALOG_PAGE: analog_page_reg <= f_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      core_mask1_reg <= `PSR_RESET_BYTE;
      buf_mask1_reg  <= `PSR_RESET_BYTE;
      core_mask2_reg <= `PSR_RESET_BYTE;
      buf_mask2_reg  <= `PSR_RESET_BYTE;
      pd_ctrl_reg    <= `PSR_RESET_BYTE;
      coupling_reg   <= `PSR_RESET_BYTE;
      mask_en_reg    <= `PSR_RESET_BYTE;
    end else if (frame_done && master_vis) begin
      case (f_addr)
        `PSR_OFS_CORE_MASK1: core_mask1_reg <= f_data;
        `PSR_OFS_BUF_MASK1:  buf_mask1_reg  <= f_data & `PSR_BUF_MASK_MASK;
        `PSR_OFS_CORE_MASK2: core_mask2_reg <= f_data;
        `PSR_OFS_BUF_MASK2:  buf_mask2_reg  <= f_data & `PSR_BUF_MASK_MASK;
        `PSR_OFS_PD_CTRL: begin
          // global bit only taken with override set
          pd_ctrl_reg <= (f_data & `PSR_PD_CTRL_MASK) &
                         {f_data[`PSR_BIT_OVERRIDE], 7'h7F};
        end
        `PSR_OFS_COUPLING:   coupling_reg   <= f_data & `PSR_LOW_BIT_MASK;
        `PSR_OFS_MASK_EN:    mask_en_reg    <= f_data & `PSR_MASK_EN_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================
  // readback
  logic [7:0]  rd_byte;
  logic [11:0] h_addr;
  logic        h_bank;
  logic        h_local;
  assign h_addr  = shift_next[11:0];
  assign h_bank  = shift_next[`PSR_HDR_BANK];
  assign h_local = !h_bank && (is_general(h_addr) ||
                   ((analog_page_reg == `PSR_PAGE_MASTER) && is_master(h_addr)));
  always_comb begin
    rd_byte = 8'h00;
    if (h_local) begin
      case (h_addr)
        `PSR_OFS_SEC_LOW:     rd_byte = sec_low_reg;
        `PSR_OFS_SEC_HIGH:    rd_byte = sec_high_reg;
        `PSR_OFS_PRI_LOW:     rd_byte = pri_low_reg;
        `PSR_OFS_PRI_HIGH:    rd_byte = pri_high_reg;
        `PSR_OFS_PAIRING:     rd_byte = pairing_reg;
        `PSR_OFS_ANALOG_PAGE: rd_byte = analog_page_reg;
        `PSR_OFS_CORE_MASK1:  rd_byte = core_mask1_reg;
        `PSR_OFS_BUF_MASK1:   rd_byte = buf_mask1_reg;
        `PSR_OFS_CORE_MASK2:  rd_byte = core_mask2_reg;
        `PSR_OFS_BUF_MASK2:   rd_byte = buf_mask2_reg;
        `PSR_OFS_PD_CTRL:     rd_byte = pd_ctrl_reg;
        `PSR_OFS_COUPLING:    rd_byte = coupling_reg;
        `PSR_OFS_MASK_EN:     rd_byte = mask_en_reg;
        default:              rd_byte = 8'h00;
      endcase
    end
  end

  // hdr_done sees the address in shift_next, so decode it from there
  logic        h_read;
  assign h_read = shift_next[`PSR_HDR_READ];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_shift_reg <= '0;
      sdout        <= 1'b0;
    end else if (state_reg == PSR_ST_IDLE) begin
      sdout <= 1'b0;
    end else if (hdr_done) begin
      rd_shift_reg <= h_read ? rd_byte : 8'h00;
    end else if (sclk_fall && cnt_reg >= `PSR_HDR_BITS && cnt_reg < `PSR_FRAME_BITS) begin
      sdout        <= rd_shift_reg[7];
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end

  // ==========================================
  // paged write forwarding
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      chan_a_write <= 1'b0;
      chan_b_write <= 1'b0;
      wr_bank      <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= '0;
    end else begin
      chan_a_write <= 1'b0;
      chan_b_write <= 1'b0;
      if (frame_done && !f_local) begin
        wr_bank      <= f_bank;
        wr_addr      <= f_addr;
        wr_data      <= f_data;
        chan_a_write <= !pairing_reg[`PSR_BIT_INDIVIDUAL] || !f_chan;
        chan_b_write <= !pairing_reg[`PSR_BIT_INDIVIDUAL] || f_chan;
      end
    end
  end

  // ==========================================
  // page and power-down outputs
  logic [7:0] core_sel;
  logic [7:0] buf_sel;
  logic       apply;
  assign core_sel = pd_ctrl_reg[`PSR_BIT_MASK_SEL] ? core_mask2_reg : core_mask1_reg;
  assign buf_sel  = pd_ctrl_reg[`PSR_BIT_MASK_SEL] ? buf_mask2_reg : buf_mask1_reg;
  assign apply    = mask_en_reg[`PSR_BIT_MASK_EN];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      link_bank_secondary_page <= '0;
      link_bank_primary_page   <= '0;
      page_main_digital        <= 1'b0;
      page_link_digital        <= 1'b0;
      page_link_analog         <= 1'b0;
      page_offset_read         <= 1'b0;
      page_offset_load         <= 1'b0;
      page_master              <= 1'b0;
      page_converter           <= 1'b0;
    end else begin
      link_bank_secondary_page <= {sec_high_reg, sec_low_reg};
      link_bank_primary_page   <= {pri_high_reg, pri_low_reg};
      page_main_digital <= {pri_high_reg, pri_low_reg} == `PSR_PAGE_MAIN_DIG;
      page_link_digital <= {pri_high_reg, pri_low_reg} == `PSR_PAGE_LINK_DIG;
      page_link_analog  <= {pri_high_reg, pri_low_reg} == `PSR_PAGE_LINK_ANA;
      page_offset_read  <= ({pri_high_reg, pri_low_reg} == `PSR_PAGE_OFFSET) &&
                           ({sec_high_reg, sec_low_reg} == `PSR_PAGE_OFS_READ);
      page_offset_load  <= ({pri_high_reg, pri_low_reg} == `PSR_PAGE_OFFSET) &&
                           ({sec_high_reg, sec_low_reg} == `PSR_PAGE_OFS_LOAD);
      page_master       <= analog_page_reg == `PSR_PAGE_MASTER;
      page_converter    <= analog_page_reg == `PSR_PAGE_CONVERTER;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      core_a_sleep         <= 1'b0;
      core_b_sleep         <= 1'b0;
      buffer_a_sleep       <= 2'b00;
      buffer_b_sleep       <= 2'b00;
      whole_chip_sleep     <= 1'b0;
      common_mode_lift_off <= 1'b0;
    end else begin
      core_a_sleep   <= apply && (&core_sel[7:4]);
      core_b_sleep   <= apply && (&core_sel[3:0]);
      buffer_a_sleep <= apply ? buf_sel[5:4] : 2'b00;
      buffer_b_sleep <= apply ? buf_sel[7:6] : 2'b00;
      whole_chip_sleep <= pd_ctrl_reg[`PSR_BIT_OVERRIDE] ?
                          pd_ctrl_reg[`PSR_BIT_GLOBAL] : pin_sync_reg[1];
      common_mode_lift_off <= coupling_reg[`PSR_BIT_LIFT_OFF];
    end
  end

endmodule

`default_nettype wire

//--- test/psr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks
module psr_regs_chk (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [15:0] link_bank_secondary_page,
  input wire logic [15:0] link_bank_primary_page,
  input wire logic        page_main_digital,
  input wire logic        page_link_digital,
  input wire logic        page_link_analog,
  input wire logic        page_offset_read,
  input wire logic        page_offset_load,
  input wire logic        chan_a_write,
  input wire logic        chan_b_write,
  input wire logic        wr_bank,
  input wire logic [11:0] wr_addr,
  input wire logic [7:0]  wr_data,
  input wire logic [1:0]  buffer_a_sleep,
  input wire logic [1:0]  buffer_b_sleep
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_still;
    ($stable(link_bank_primary_page) && $stable(link_bank_secondary_page)) [*3];
  endsequence
  sequence s_pulse;
    chan_a_write || chan_b_write;
  endsequence
  property p_main;
    s_still |-> page_main_digital == (link_bank_primary_page == 16'h6800);
  endproperty
  property p_ldig;
    s_still |-> page_link_digital == (link_bank_primary_page == 16'h6900);
  endproperty
  property p_lana;
    s_still |-> page_link_analog == (link_bank_primary_page == 16'h6A00);
  endproperty
  property p_ofs_rd;
    s_still |-> page_offset_read == (link_bank_primary_page == 16'h6100 && link_bank_secondary_page == 16'h0000);
  endproperty
  property p_ofs_ld;
    s_still |-> page_offset_load == (link_bank_primary_page == 16'h6100 && link_bank_secondary_page == 16'h0500);
  endproperty
  property p_pulse;
    s_pulse |=> !chan_a_write && !chan_b_write;
  endproperty
  property p_hold;
    !chan_a_write && !chan_b_write |-> $stable({wr_bank, wr_addr, wr_data});
  endproperty
  property p_buf;
    buffer_a_sleep[1] == buffer_a_sleep[0] && buffer_b_sleep[1] == buffer_b_sleep[0];
  endproperty
  a_main: assert property (p_main) else $error("main digital page flag wrong");
  a_ldig: assert property (p_ldig) else $error("link digital page flag wrong");
  a_lana: assert property (p_lana) else $error("link analog page flag wrong");
  a_ofs_rd: assert property (p_ofs_rd) else $error("offset read page flag wrong");
  a_ofs_ld: assert property (p_ofs_ld) else $error("offset load page flag wrong");
  a_pulse: assert property (p_pulse) else $error("channel write pulse too long");
  a_hold: assert property (p_hold) else $error("forwarded write changed without pulse");
  a_buf: assert property (p_buf) else $error("buffer sleep field split");
endmodule
bind psr_regs psr_regs_chk u_chk (.core_clk, .nrst, .link_bank_secondary_page, .link_bank_primary_page,
  .page_main_digital, .page_link_digital, .page_link_analog, .page_offset_read, .page_offset_load,
  .chan_a_write, .chan_b_write, .wr_bank, .wr_addr, .wr_data, .buffer_a_sleep, .buffer_b_sleep);
`default_nettype wire

//--- test/psr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench top
module psr_regs_tb_top;
  logic        core_clk, nrst, sen_n, sclk, sdin, sleep_pin, sdout, wr_bank;
  logic        page_main_digital, page_link_digital, page_link_analog, page_offset_read;
  logic        page_offset_load, page_master, page_converter, chan_a_write, chan_b_write;
  logic        core_a_sleep, core_b_sleep, whole_chip_sleep, common_mode_lift_off;
  logic [15:0] link_bank_secondary_page, link_bank_primary_page;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic [1:0]  buffer_a_sleep, buffer_b_sleep;
  logic [7:0]  r [0:127];
  logic [20:0] ewr;
  logic [31:0] seed = 32'hDB42FA12;
  logic        rdf = 1'b0;
  logic [15:0] pg [5] = '{16'h6800, 16'h6900, 16'h6A00, 16'h6100, 16'h6180};
  logic [7:0]  cv [4] = '{8'hF0, 8'h0F, 8'hFF, 8'h00};
  logic [11:0] adr [15] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h011, 12'h020, 12'h021,
                            12'h023, 12'h024, 12'h026, 12'h04F, 12'h055, 12'h0E7, 12'h300};
  int          n_errors = 0, n_checks = 0, na = 0, nb = 0, ea = 0, eb = 0, cyc = 0;

  psr_regs dut (.core_clk, .nrst, .sen_n, .sclk, .sdin, .sleep_pin, .sdout, .link_bank_secondary_page,
    .link_bank_primary_page, .page_main_digital, .page_link_digital, .page_link_analog, .page_offset_read,
    .page_offset_load, .page_master, .page_converter, .chan_a_write, .chan_b_write, .wr_bank, .wr_addr,
    .wr_data, .core_a_sleep, .core_b_sleep, .buffer_a_sleep, .buffer_b_sleep, .whole_chip_sleep,
    .common_mode_lift_off);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (chan_a_write === 1'b1) na++;
    if (chan_b_write === 1'b1) nb++;
    if (cyc == 40000) begin
      n_errors++;
      conclude;
    end
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic conclude;
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cmp_all;
    logic [15:0] p, s;
    logic [7:0]  c, b;
    logic        e;
    p = {r[7'h04], r[7'h03]};
    s = {r[7'h02], r[7'h01]};
    e = r[7'h55][4];
    c = r[7'h26][5] ? r[7'h23] : r[7'h20];
    b = r[7'h26][5] ? r[7'h24] : r[7'h21];
    chk(link_bank_secondary_page, s);
    chk(link_bank_primary_page, p);
    chk({page_main_digital, page_link_digital, page_link_analog}, {p == 16'h6800, p == 16'h6900, p == 16'h6A00});
    chk({page_offset_read, page_offset_load}, {p == 16'h6100 && s == 16'h0000, p == 16'h6100 && s == 16'h0500});
    chk({page_master, page_converter}, {r[7'h11] == 8'h80, r[7'h11] == 8'h0F});
    chk({core_a_sleep, core_b_sleep}, {e & (&c[7:4]), e & (&c[3:0])});
    chk({buffer_b_sleep, buffer_a_sleep}, e ? b[7:4] : 4'h0);
    chk(whole_chip_sleep, r[7'h26][7] | (~r[7'h26][6] & sleep_pin));
    chk(common_mode_lift_off, r[7'h4F][0]);
    chk({na[7:0], nb[7:0]}, {ea[7:0], eb[7:0]});
    chk(ewr, {wr_bank, wr_addr, wr_data});
  endtask

  task automatic mwr(input logic bank, input logic ch, input logic [11:0] a, input logic [7:0] d);
    ea = 0;
    eb = 0;
    if (a <= 12'h011 || (!bank && r[7'h11] == 8'h80 && a inside {12'h020, 12'h021, 12'h023, 12'h024,
        12'h026, 12'h04F, 12'h055})) begin
      case (a)
        12'h005, 12'h04F: d = d & 8'h01;
        12'h021, 12'h024: d = d & 8'hF0;
        12'h026: d = d & (d[6] ? 8'hE0 : 8'h60);
        12'h055: d = d & 8'h10;
        default: ;
      endcase
      r[a[6:0]] = d;
    end else begin
      ea = !r[7'h05][0] || !ch;
      eb = !r[7'h05][0] || ch;
      ewr = {bank, a, d};
    end
  endtask

  // ==========================================
  // serial frame, msb first, data set while clock low
  task automatic frame(input logic bank, input logic ch, input logic [11:0] a, input logic [7:0] d);
    logic [23:0] f;
    logic [7:0]  rb;
    logic [7:0]  xr;
    f = {rdf, bank, ch, 1'b0, a, d};
    rb = 8'h00;
    xr = (!bank && (a inside {12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h011} ||
         (r[7'h11] == 8'h80 && a inside {12'h020, 12'h021, 12'h023, 12'h024, 12'h026, 12'h04F, 12'h055})))
         ? r[a[6:0]] : 8'h00;
    na = 0;
    nb = 0;
    sen_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = f[i];
      repeat (3) @(negedge core_clk);
      if (i < 8) rb = {rb[6:0], sdout};
      sclk = 1'b1;
      repeat (3) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge core_clk);
    sen_n = 1'b1;
    sdin = ~sdin;
    repeat (10) @(negedge core_clk);
    if (rdf) begin
      ea = 0;
      eb = 0;
      chk(rb, xr);
    end else begin
      mwr(bank, ch, a, d);
    end
    cmp_all;
  endtask

  task automatic w(input logic [11:0] a, input logic [7:0] d);
    frame(1'b0, 1'b0, a, d);
  endtask

  task automatic pin(input logic v);
    sleep_pin = v;
    repeat (8) @(negedge core_clk);
    cmp_all;
  endtask

  task automatic do_reset;
    nrst = 1'b0;
    sleep_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    foreach (r[i]) r[i] = 8'h00;
    ewr = '0;
    na = 0;
    nb = 0;
    ea = 0;
    eb = 0;
    repeat (4) @(negedge core_clk);
    cmp_all;
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] v;
    logic [11:0] a;
    logic [7:0]  d;
    nrst = 1'b0;
    sen_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
    sleep_pin = 1'b0;
    do_reset;
    for (int i = 0; i < 5; i++) begin
      w(12'h004, pg[i][15:8]);
      w(12'h003, pg[i][7:0]);
    end
    w(12'h003, 8'h00);
    w(12'h002, 8'h05);
    w(12'h001, 8'h5A);
    w(12'h001, 8'h00);
    w(12'h002, 8'h00);
    w(12'h011, 8'h0F);
    w(12'h026, 8'hC0);
    w(12'h04F, 8'h01);
    w(12'h011, 8'h80);
    frame(1'b1, 1'b1, 12'h04F, 8'h01);
    w(12'h021, 8'hFF);
    w(12'h023, 8'h0F);
    w(12'h024, 8'hC0);
    w(12'h055, 8'h10);
    for (int j = 0; j < 4; j++) w(12'h020, cv[j]);
    w(12'h020, 8'hF0);
    w(12'h026, 8'h20);
    w(12'h055, 8'h00);
    w(12'h055, 8'h10);
    w(12'h026, 8'h80);
    pin(1'b1);
    pin(1'b0);
    w(12'h026, 8'hC0);
    pin(1'b1);
    pin(1'b0);
    w(12'h026, 8'h40);
    pin(1'b1);
    w(12'h026, 8'h00);
    pin(1'b0);
    w(12'h04F, 8'hFF);
    w(12'h04F, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      w(12'h005, {7'h00, k[1]});
      frame(v[0], k[0], 12'h1A0, v[15:8]);
    end
    repeat (40) begin
      v = rnd();
      a = adr[v[3:0] % 15];
      d = v[15:8];
      if (a == 12'h021 || a == 12'h024) d = {{2{d[7]}}, {2{d[5]}}, d[3:0]};
      if (a == 12'h011 && v[16]) d = 8'h80;
      sleep_pin = v[17];
      rdf = v[20];
      frame(v[18] && a > 12'h011, v[19], a, d);
      rdf = 1'b0;
    end
    do_reset;
    w(12'h003, 8'h5A);
    conclude;
  end
endmodule
`default_nettype wire
